//--- hw/adsc_defs.vh
`ifndef ADSC_DEFS_VH
`define ADSC_DEFS_VH

// ----------------------------------------------------------------------
// register addresses (low 16 bits of the cpu address)
// ----------------------------------------------------------------------
`define ADSC_ADDR_RES_A_HI   16'hffe0
`define ADSC_ADDR_RES_A_LO   16'hffe1
`define ADSC_ADDR_RES_B_HI   16'hffe2
`define ADSC_ADDR_RES_B_LO   16'hffe3
`define ADSC_ADDR_RES_C_HI   16'hffe4
`define ADSC_ADDR_RES_C_LO   16'hffe5
`define ADSC_ADDR_RES_D_HI   16'hffe6
`define ADSC_ADDR_RES_D_LO   16'hffe7
`define ADSC_ADDR_CSR        16'hffe8
`define ADSC_ADDR_TRIG       16'hffe9
`define ADSC_ADDR_RES_BASE   16'hffe0
`define ADSC_ADDR_RES_MASK   16'hfff8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ADSC_CSR_RST         8'h00
`define ADSC_TRIG_RST        8'h7e
`define ADSC_RES_RST         10'h000
`define ADSC_TRIG_RSVD       7'h7e
`define ADSC_RD_UNMAPPED     8'hff

// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define ADSC_CSR_END         7
`define ADSC_CSR_IE          6
`define ADSC_CSR_START       5
`define ADSC_CSR_SCAN        4
`define ADSC_CSR_SPEED       3
`define ADSC_CSR_GROUP       2
`define ADSC_TRIG_EN         7

// ----------------------------------------------------------------------
// conversion timing in states (one state per clock)
// ----------------------------------------------------------------------
`define ADSC_CONV_SLOW_FIRST 9'd266
`define ADSC_CONV_FAST_FIRST 9'd134
`define ADSC_CONV_SLOW_NEXT  9'd256
`define ADSC_CONV_FAST_NEXT  9'd128
`define ADSC_CNT_ONE         9'd1

`endif

//--- hw/adsc_top.v
// Notes on behaviour
// - each conversion writes 10-bit result to slot
// - top eight bits high byte, two bits low
// - low byte bits 5..0 read zero
// - high byte direct, low byte via latch
// - result slots cleared by reset and standby
// - inputs n and n+4 share slot n
// - control/status cleared by reset and standby
// - end flag on single end or scan pass
// - end flag cleared by read-one then write-zero
// - interrupt enable gates end-flag interrupt request
// - start bit reads one while converting; trigger sets
// - single mode start bit clears itself at end
// - scan mode cycles until start bit cleared
// - start bit zero means converter stopped
// - mode bit zero single, one scan
// - speed bit selects 266 or 134 states
// - single mode group bit plus two-bit index
// - scan covers first input to indexed input
// - inputs 0-3 group zero, 4-7 group one
// - trigger falling edge starts only when enabled
// - high byte read copies low byte to latch
// - scan next channel starts immediately
// - later scan conversions take 256 or 128 states
`timescale 1ns/1ps
`include "adsc_defs.vh"

module adsc_top
(
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    input  wire        standby,
    // cpu byte bus
    input  wire [15:0] cpu_addr,
    input  wire        cpu_rd,
    input  wire        cpu_wr,
    input  wire [7:0]  cpu_wdata,
    output reg  [7:0]  cpu_rdata,
    // external trigger, active low falling edge
    input  wire        ext_trigger_pin,
    // analog core black box
    output reg         core_start,
    output reg  [2:0]  core_channel,
    input  wire [9:0]  core_result,
    // end-of-conversion interrupt request
    output reg         conv_end_irq
);

    // ------------------------------------------------------------------
    // state codes, one-hot
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;   // converter stopped
    localparam [1:0] ST_CONV = 2'b10;   // conversion in progress

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg  [9:0] result_reg [0:3];        // one 10-bit slot per pair of inputs
    reg  [7:0] temp_latch_reg;          // low-byte holding latch
    reg        conv_end_flag_reg;       // sticky end flag
    reg        end_irq_enable_reg;
    reg        conv_start_bit_reg;
    reg        scan_mode_reg;
    reg        conv_speed_select_reg;
    reg  [2:0] chan_sel_reg;            // group_select, channel_index_hi/lo
    reg        ext_trigger_enable_reg;
    reg        end_flag_seen_reg;       // flag was read while one
    reg        trig_prev_reg;           // last trigger pin level
    reg  [1:0] state_reg;
    reg  [8:0] count_reg;               // states left in this conversion
    reg  [1:0] slot_reg;                // index within group being converted

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire       sel_csr   = (cpu_addr == `ADSC_ADDR_CSR);
    wire       sel_trig  = (cpu_addr == `ADSC_ADDR_TRIG);
    wire       sel_res   = ((cpu_addr & `ADSC_ADDR_RES_MASK) == `ADSC_ADDR_RES_BASE);
    wire [1:0] res_idx   = cpu_addr[2:1];
    wire       res_is_lo = cpu_addr[0];
    wire       csr_wr    = cpu_wr & sel_csr;
    wire       trig_wr   = cpu_wr & sel_trig;
    // falling edge on the trigger pin while triggering is enabled
    wire       trig_fall = ext_trigger_enable_reg & trig_prev_reg & ~ext_trigger_pin;
    // software write of the start bit, or the pin event
    wire       start_req = (csr_wr & cpu_wdata[`ADSC_CSR_START]) | trig_fall;
    // conversion finishing in this cycle
    wire       conv_done = (state_reg == ST_CONV) & (count_reg == `ADSC_CNT_ONE);
    // last channel of the scan group reached
    wire       last_slot = (slot_reg == chan_sel_reg[1:0]);
    wire       pass_done = conv_done & (~scan_mode_reg | last_slot);
    wire [2:0] csr_rd_val = {conv_end_flag_reg, end_irq_enable_reg, conv_start_bit_reg};

    // ------------------------------------------------------------------
    // cpu read data and low-byte latch
    // ------------------------------------------------------------------
    // high-byte read loads the latch so the pair is coherent
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cpu_rdata      <= 8'h00;
            temp_latch_reg <= 8'h00;
        end
        else if (standby)
        begin
            cpu_rdata      <= 8'h00;
            temp_latch_reg <= 8'h00;
        end
        else if (cpu_rd)
        begin
            if (sel_res & ~res_is_lo)
            begin
                cpu_rdata      <= result_reg[res_idx][9:2];
                temp_latch_reg <= {result_reg[res_idx][1:0], 6'b000000};
            end
            else if (sel_res)
                cpu_rdata <= temp_latch_reg;
            else if (sel_csr)
                cpu_rdata <= {csr_rd_val, scan_mode_reg,
                              conv_speed_select_reg, chan_sel_reg};
            else if (sel_trig)
                cpu_rdata <= {ext_trigger_enable_reg, `ADSC_TRIG_RSVD};
            else
                cpu_rdata <= `ADSC_RD_UNMAPPED;                             // unmapped
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // standby acts as a synchronous clear; reset is asynchronous
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            end_irq_enable_reg     <= 1'b0;
            scan_mode_reg          <= 1'b0;
            conv_speed_select_reg  <= 1'b0;
            chan_sel_reg           <= 3'b000;
            ext_trigger_enable_reg <= 1'b0;
        end
        else if (standby)
        begin
            end_irq_enable_reg     <= 1'b0;
            scan_mode_reg          <= 1'b0;
            conv_speed_select_reg  <= 1'b0;
            chan_sel_reg           <= 3'b000;
            ext_trigger_enable_reg <= 1'b0;
        end
        else
        begin
            // settings take effect at once; software is expected
            // to stop conversion first, so no interlock here
            if (csr_wr)
            begin
                end_irq_enable_reg    <= cpu_wdata[`ADSC_CSR_IE];
                scan_mode_reg         <= cpu_wdata[`ADSC_CSR_SCAN];
                conv_speed_select_reg <= cpu_wdata[`ADSC_CSR_SPEED];
                chan_sel_reg          <= cpu_wdata[`ADSC_CSR_GROUP:0];
            end
            if (trig_wr)
                ext_trigger_enable_reg <= cpu_wdata[`ADSC_TRIG_EN];
        end
    end

    // ------------------------------------------------------------------
    // end flag with read-then-write-zero clear
    // ------------------------------------------------------------------
    // a new end event in the clearing cycle wins over the clear
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            conv_end_flag_reg <= 1'b0;
            end_flag_seen_reg <= 1'b0;
        end
        else if (standby)
        begin
            conv_end_flag_reg <= 1'b0;
            end_flag_seen_reg <= 1'b0;
        end
        else if (pass_done)
        begin
            conv_end_flag_reg <= 1'b1;
            end_flag_seen_reg <= 1'b0;
        end
        else
        begin
            if (cpu_rd & sel_csr & conv_end_flag_reg)
                end_flag_seen_reg <= 1'b1;
            // writing one never sets the flag
            if (csr_wr & ~cpu_wdata[`ADSC_CSR_END] & end_flag_seen_reg)
            begin
                conv_end_flag_reg <= 1'b0;
                end_flag_seen_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    // start bit mirrors the busy state: set by start, cleared by
    // software, end of single conversion, reset or standby
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg          <= ST_IDLE;
            conv_start_bit_reg <= 1'b0;
            count_reg          <= `ADSC_CNT_ONE;
            slot_reg           <= 2'b00;
            core_start         <= 1'b0;
            core_channel       <= 3'b000;
        end
        else if (standby)
        begin
            state_reg          <= ST_IDLE;
            conv_start_bit_reg <= 1'b0;
            count_reg          <= `ADSC_CNT_ONE;
            slot_reg           <= 2'b00;
            core_start         <= 1'b0;
            core_channel       <= 3'b000;
        end
        else
        begin
            core_start <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (start_req)
                    begin
                        // scan always begins at the group's first input
                        state_reg          <= ST_CONV;
                        conv_start_bit_reg <= 1'b1;
                        slot_reg           <= (cpu_wdata[`ADSC_CSR_SCAN] & csr_wr) |
                                              (scan_mode_reg & ~csr_wr) ?
                                              2'b00 :
                                              (csr_wr ? cpu_wdata[1:0] : chan_sel_reg[1:0]);
                        core_channel       <= csr_wr ?
                            {cpu_wdata[`ADSC_CSR_GROUP],
                             ((cpu_wdata[`ADSC_CSR_SCAN]) ? 2'b00 : cpu_wdata[1:0])} :
                            {chan_sel_reg[2], (scan_mode_reg ? 2'b00 : chan_sel_reg[1:0])};
                        core_start         <= 1'b1;
                        count_reg          <= (csr_wr ? cpu_wdata[`ADSC_CSR_SPEED] :
                                               conv_speed_select_reg) ?
                                              `ADSC_CONV_FAST_FIRST : `ADSC_CONV_SLOW_FIRST;
                    end
                end
                ST_CONV:
                begin
                    if (csr_wr & ~cpu_wdata[`ADSC_CSR_START])
                    begin
                        // software stop abandons the conversion
                        state_reg          <= ST_IDLE;
                        conv_start_bit_reg <= 1'b0;
                    end
                    else if (conv_done & ~scan_mode_reg)
                    begin
                        state_reg          <= ST_IDLE;
                        conv_start_bit_reg <= 1'b0;
                    end
                    else if (conv_done)
                    begin
                        // next channel, wrap after the indexed input
                        slot_reg     <= last_slot ? 2'b00 : slot_reg + 2'b01;
                        core_channel <= {chan_sel_reg[2],
                                         (last_slot ? 2'b00 : slot_reg + 2'b01)};
                        core_start   <= 1'b1;
                        count_reg    <= conv_speed_select_reg ?
                                        `ADSC_CONV_FAST_NEXT : `ADSC_CONV_SLOW_NEXT;
                    end
                    else
                        count_reg <= count_reg - `ADSC_CNT_ONE;
                end
                default:
                begin
                    state_reg          <= ST_IDLE;
                    conv_start_bit_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // result slots, one per generate entry
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_slot
            // slot gi serves input gi of either group
            // the group bit is ignored here, which is the slot sharing
            always @(posedge clock or posedge rst)
            begin
                if (rst)
                    result_reg[gi] <= `ADSC_RES_RST;
                else if (standby)
                    result_reg[gi] <= `ADSC_RES_RST;
                else if (conv_done & ({30'h0, core_channel[1:0]} == gi))
                    result_reg[gi] <= core_result;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    // level request while flag and enable are both set; pass_done is
    // folded in so the request rises on the same edge as the flag
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            conv_end_irq <= 1'h0;
        else if (standby)
            conv_end_irq <= 1'h0;
        else
            conv_end_irq <= end_irq_enable_reg & (conv_end_flag_reg | pass_done);
    end

    // ------------------------------------------------------------------
    // trigger pin history
    // ------------------------------------------------------------------
    // previous pin level for the falling-edge detector; it starts low,
    // so a pin already low when reset lifts is not taken for an edge,
    // at the cost of missing a real fall in the very first cycle
    always @(posedge clock or posedge rst)
    begin
        if (rst)
            trig_prev_reg <= 1'h0;
        else if (standby)
            trig_prev_reg <= 1'h0;
        else
            trig_prev_reg <= ext_trigger_pin;
    end

endmodule // adsc_top

//--- verif/adsc_top_chk.sv
`timescale 1ns/1ps
// ----------
// port checker
// ----------
module adsc_top_chk
(
    // clock and reset
    input wire        clock,
    input wire        rst,
    input wire        standby,
    // cpu byte bus
    input wire [15:0] cpu_addr,
    input wire        cpu_rd,
    input wire        cpu_wr,
    input wire [7:0]  cpu_wdata,
    input wire [7:0]  cpu_rdata,
    // trigger, core, interrupt
    input wire        ext_trigger_pin,
    input wire        core_start,
    input wire [2:0]  core_channel,
    input wire [9:0]  core_result,
    input wire        conv_end_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic [7:0] ctl_q;    // last csr value written
    logic       trg_en_q; // trigger enable copy
    logic       pin_q;    // pin one clock ago
    logic       run_q;    // scan run under way
    logic       first_q;  // last start opened the run
    logic [9:0] cnt_q;    // clocks since last start
    wire        csr_wr = cpu_wr && cpu_addr == 16'hffe8;
    wire        cmd = (csr_wr && cpu_wdata[5]) || (trg_en_q && pin_q && !ext_trigger_pin);
    wire [9:0]  gap = first_q ? (ctl_q[3] ? 10'h086 : 10'h10a) : (ctl_q[3] ? 10'h080 : 10'h100);

    // mirror of the settings; standby wipes it as it wipes the block
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            {ctl_q, trg_en_q, pin_q, run_q, first_q, cnt_q} <= '0;
        else if (standby)
            {ctl_q, trg_en_q, pin_q, run_q, first_q, cnt_q} <= '0;
        else
        begin
            pin_q <= ext_trigger_pin;
            cnt_q <= core_start ? 10'h001 : cnt_q + 10'h001;
            if (csr_wr)
                ctl_q <= cpu_wdata;
            if (cpu_wr && cpu_addr == 16'hffe9)
                trg_en_q <= cpu_wdata[7];
            // a stop write ends the run, a flag-clear write keeps it
            if (csr_wr && !cpu_wdata[5])
                run_q <= 1'b0;
            else if (core_start && ctl_q[4])
                run_q <= 1'b1;
            if (core_start)
                first_q <= !run_q;
        end
    end

    // start that must answer to a request
    sequence s_fresh_start;
        core_start && !run_q;
    endsequence
    // scan start following the last one
    sequence s_next_start;
        core_start && run_q && ctl_q[4];
    endsequence

    a_start_cause: assert property (s_fresh_start |-> $past(cmd) || $past(cmd, 2))
        else $error("start with no request");
    a_scan_gap: assert property (s_next_start |-> cnt_q == gap)
        else $error("scan start spacing off");
    a_irq_gated: assert property (!ctl_q[6] && !$past(ctl_q[6]) |-> !conv_end_irq)
        else $error("request while disabled");
    a_unmapped_ff: assert property (cpu_rd && (cpu_addr < 16'hffe0 || cpu_addr > 16'hffe9)
        |=> cpu_rdata == 8'hff)
        else $error("unmapped read value");
    a_trig_read: assert property (cpu_rd && cpu_addr == 16'hffe9 |=> cpu_rdata == {trg_en_q, 7'h7e})
        else $error("trigger register readback");
    a_low_zero: assert property (cpu_rd && cpu_addr[15:3] == 13'h1ffc && cpu_addr[0]
        |=> cpu_rdata[5:0] == 6'h00)
        else $error("low byte spare bits set");
    a_csr_config: assert property (cpu_rd && cpu_addr == 16'hffe8
        |=> {cpu_rdata[6], cpu_rdata[4:0]} == {ctl_q[6], ctl_q[4:0]})
        else $error("csr settings readback");
    a_single_chan: assert property (core_start && !ctl_q[4] |-> core_channel == ctl_q[2:0])
        else $error("single channel off");
    a_standby_clear: assert property (standby |=> !cpu_rdata && !conv_end_irq && !core_start)
        else $error("standby left state");
endmodule // adsc_top_chk

bind adsc_top adsc_top_chk u_chk
(
    .clock(clock), .rst(rst), .standby(standby), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
    .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .ext_trigger_pin(ext_trigger_pin), .core_start(core_start), .core_channel(core_channel),
    .core_result(core_result), .conv_end_irq(conv_end_irq)
);

//--- verif/adsc_core_model.sv
`timescale 1ns/1ps
// ----------
// analog core stand-in
// ----------
module adsc_core_model
(
    input  wire        clock,
    input  wire        core_start,
    input  wire  [2:0] core_channel,
    output logic [9:0] core_result
);
    logic [9:0] held = 10'h155; // code of the channel converting
    logic [8:0] age = 9'h1ff;   // clocks since the last start

    // code names the channel in the high byte and its low two bits in the low byte
    always_ff @(posedge clock)
    begin
        if (core_start)
        begin
            held <= {core_channel, 4'hb, core_channel};
            age  <= 9'h000;
        end
        else if (age != 9'h1ff)
            age <= age + 9'h001;
    end
    // past the longest conversion the code is not held, so scramble it
    assign core_result = (age < 9'h12c) ? held : ~held ^ {1'b0, age};
endmodule // adsc_core_model

//--- verif/adc_sequencer_control_tb.sv
`timescale 1ns/1ps
// ----------
// bench for the converter control block
// ----------
module adc_sequencer_control_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        standby = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic        cpu_rd = 1'b0;
    logic        cpu_wr = 1'b0;
    logic [7:0]  cpu_wdata = 8'h00;
    logic        ext_trigger_pin = 1'b1; // idles high, starts on a fall
    logic [7:0]  cpu_rdata;
    logic        core_start;
    logic [2:0]  core_channel;
    logic [9:0]  core_result;
    logic        conv_end_irq;
    int          mismatches = 0;
    int          comparisons = 0;

    // 100 MHz clock
    always #5 clock = ~clock;

    adsc_top u_dut
    (
        .clock(clock), .rst(rst), .standby(standby), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .ext_trigger_pin(ext_trigger_pin), .core_start(core_start),
        .core_channel(core_channel), .core_result(core_result), .conv_end_irq(conv_end_irq)
    );
    adsc_core_model u_core
    (
        .clock(clock), .core_start(core_start), .core_channel(core_channel),
        .core_result(core_result)
    );

    // result bytes expected for a channel's code
    function automatic logic [7:0] hi(input logic [2:0] c);
        return {c, 4'hb, c[2]};
    endfunction
    function automatic logic [7:0] lo(input logic [2:0] c);
        return {c[1:0], 6'h00};
    endfunction

    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        comparisons++;
        if (exp !== got)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobes last one clock; an edge always passes before the next
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock) #1 {cpu_addr, cpu_wdata, cpu_wr} = {a, v, 1'b1};
        @(posedge clock) #1 cpu_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clock) #1 {cpu_addr, cpu_rd} = {a, 1'b1};
        @(posedge clock) #1 cpu_rd = 1'b0;
        chk(what, 10'(exp), 10'(cpu_rdata));
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 400 && conv_end_irq !== 1'b1; i++)
            @(posedge clock) #1;
        chk("irq", 10'h001, 10'(conv_end_irq));
    endtask
    // count starts over a span, keep the last channel
    task automatic watch(input int cyc, output int n, output logic [2:0] ch);
        n = 0;
        ch = 3'h0;
        repeat (cyc)
        begin
            if (core_start === 1'b1)
            begin
                n++;
                ch = core_channel;
            end
            @(posedge clock) #1;
        end
    endtask

    task automatic t_reset;
        for (int a = 0; a < 8; a++)
            rd(16'hffe0 + 16'(a), 8'h00, "result reset");
        rd(16'hffe8, 8'h00, "csr reset");
        wr(16'hffe8, 8'h80);
        rd(16'hffe8, 8'h00, "flag write one");
        rd(16'hffe9, 8'h7e, "trigger reset");
        wr(16'hffe1, 8'hff);
        rd(16'hffe1, 8'h00, "result read only");
        rd(16'hffea, 8'hff, "unmapped");
    endtask
    // every input once, both speeds
    task automatic t_single;
        logic [7:0] cfg;
        for (int c = 0; c < 8; c++)
        begin
            cfg = {4'h4, c[0], 3'(c)};
            wr(16'hffe8, cfg | 8'h20);
            wait_irq();
            if (c == 0)
                wr(16'hffe8, cfg);
            rd(16'hffe8, cfg | 8'h80, "csr after end");
            wr(16'hffe8, cfg);
            rd(16'hffe8, cfg, "flag cleared");
            chk("irq cleared", 10'h000, 10'(conv_end_irq));
            rd(16'hffe0 + 16'(2 * (c % 4)), hi(3'(c)), "result high");
            rd(16'hffe1 + 16'(2 * (c % 4)), lo(3'(c)), "result low");
        end
    endtask
    task automatic t_scan;
        logic [2:0] want [4] = '{3'h4, 3'h5, 3'h6, 3'h4};
        int n;
        logic [2:0] ch;
        wr(16'hffe8, 8'h3e);
        for (int k = 0; k < 4; k++)
        begin
            for (int i = 0; i < 300 && core_start !== 1'b1; i++)
                @(posedge clock) #1;
            chk("scan channel", 10'(want[k]), 10'(core_channel));
            @(posedge clock) #1;
        end
        chk("irq masked", 10'h000, 10'(conv_end_irq));
        rd(16'hffe8, 8'hbe, "scan csr");
        wr(16'hffe8, 8'h1e);
        watch(300, n, ch);
        chk("starts after stop", 10'h000, 10'(n));
        rd(16'hffe2, hi(3'h5), "slot b high");
        rd(16'hffe1, lo(3'h5), "latched low");
        rd(16'hffe4, hi(3'h6), "slot c high");
        rd(16'hffe6, hi(3'h7), "slot d high");
    endtask
    task automatic t_trigger;
        int n;
        logic [2:0] ch;
        wr(16'hffe8, 8'h43);
        ext_trigger_pin = 1'b0;
        watch(20, n, ch);
        chk("trigger off", 10'h000, 10'(n));
        ext_trigger_pin = 1'b1;
        wr(16'hffe9, 8'h80);
        rd(16'hffe9, 8'hfe, "trigger enabled");
        ext_trigger_pin = 1'b0;
        watch(4, n, ch);
        chk("trigger start", 10'h001, 10'(n));
        chk("trigger channel", 10'h003, 10'(ch));
        rd(16'hffe8, 8'h63, "start bit busy");
        wait_irq();
        ext_trigger_pin = 1'b1;
        rd(16'hffe6, hi(3'h3), "trigger result");
    endtask
    task automatic t_standby;
        int n;
        logic [2:0] ch;
        wr(16'hffe8, 8'h70);
        watch(600, n, ch);
        chk("scan restarts", 10'h003, 10'(n));
        chk("scan one channel", 10'h000, 10'(ch));
        standby = 1'b1;
        @(posedge clock) #1 standby = 1'b0;
        watch(300, n, ch);
        chk("standby starts", 10'h000, 10'(n));
        rd(16'hffe8, 8'h00, "csr standby");
        rd(16'hffe9, 8'h7e, "trigger standby");
        rd(16'hffe6, 8'h00, "result standby");
    endtask

    task automatic give_verdict;
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        #1 rst = 1'b0;
        t_reset();
        t_single();
        t_scan();
        t_trigger();
        t_standby();
        give_verdict();
    end
    // hang guard, several times the expected run
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        give_verdict();
    end
endmodule // adc_sequencer_control_tb
